// [include/rcf_pkg.sv]
// Package for the reset-cause flag block: offsets, bit positions, reset values and carriers
package rcf_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4; // Byte address width of the register port
    localparam int DATA_W = 16; // Register data width
    localparam int OSC_W = 3; // Width of an oscillator source code

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 4'h0; // reset_cause_control
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 4'h4; // Sticky event status, read clears
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 4'h8; // Interrupt mask, same layout
    localparam logic [ADDR_W-1:0] OFF_CLK_STATUS = 4'hC; // Clock source chosen at last reset

    // ------------------------------------------------------------
    // Bit positions of reset_cause_control
    // ------------------------------------------------------------
    localparam int BIT_POWER_ON = 0; // Power-on flag
    localparam int BIT_BROWN_OUT = 1; // Brown-out flag
    localparam int BIT_IDLE = 2; // Idle flag
    localparam int BIT_SLEEP = 3; // Sleep flag
    localparam int BIT_WDT_TIMEOUT = 4; // watchdog_timeout_flag
    localparam int BIT_SOFT_WDT_EN = 5; // soft_watchdog_enable
    localparam int BIT_SOFT_RESET = 6; // soft_reset_flag
    localparam int BIT_PIN_RESET = 7; // pin_reset_flag
    localparam int BIT_CFG_MISMATCH = 9; // config_mismatch_flag
    localparam int BIT_DEEP_SLEEP = 10; // deep_sleep_flag
    localparam int BIT_ILLEGAL_OP = 14; // illegal_op_flag
    localparam int BIT_TRAP_CONFLICT = 15; // trap_conflict_flag

    // Implemented bits; all others read as zero
    localparam logic [DATA_W-1:0] RESET_CAUSE_MASK = 16'hC6FF;
    // Power-on value: power-on and brown-out flags set
    localparam logic [DATA_W-1:0] RESET_CAUSE_POR = 16'h0003;
    // Events that are device resets and so pick a clock source
    localparam logic [DATA_W-1:0] RESET_EVENT_MASK = 16'hC2D2;
    // Zero word
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    // Pin synchroniser reset: reset pin released, brown-out detector quiet
    localparam logic [1:0] SYNC_RESET_VALUE = 2'h1;
    // Synchroniser lanes
    localparam int LANE_PIN = 0; // master_clear_pin, active low
    localparam int LANE_BOR = 1; // Brown-out detector, active high

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // One-cycle event pulses from logic on the same clock
    typedef struct packed {
        logic trap_conflict; // Trap conflict reset
        logic illegal_op; // Illegal opcode or uninitialised register access
        logic config_mismatch; // Configuration mismatch reset
        logic soft_reset; // Software reset instruction executed
        logic wdt_expire; // Watchdog expired
        logic save_sleep; // power_save_instruction with sleep operand
        logic save_idle; // power_save_instruction with idle operand
    } rcf_events_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr; // Byte address
        logic [DATA_W-1:0] wdata; // Write data
        logic write; // Write strobe
        logic read; // Read strobe
    } rcf_bus_req_t;

    // Configuration fuses and oscillator fields, static levels
    typedef struct packed {
        logic watchdog_fuse_enable; // '1' means watchdog always runs
        logic clock_switch_enable; // Clock switching enabled
        logic [OSC_W-1:0] new_osc_fuse; // Fuse oscillator selection
        logic [OSC_W-1:0] current_osc_field; // Current oscillator field
        logic deep_sleep_enable; // Deep sleep enable of deep_sleep_control
    } rcf_config_t;

    // Whole state of the main module
    typedef struct packed {
        logic [DATA_W-1:0] reset_cause; // reset_cause_control contents
        logic [DATA_W-1:0] int_status; // Sticky event bits
        logic [DATA_W-1:0] int_mask; // Interrupt mask
        logic [OSC_W-1:0] clk_src; // Clock source chosen at last reset
        logic por_pending; // Power-on choice still to be made
        logic [DATA_W-1:0] rdata; // Read data, one cycle after strobe
        logic pin_prev; // Previous synchronised pin level
        logic bor_prev; // Previous synchronised brown-out level
    } rcf_state_t;

    // State of the synchroniser
    typedef struct packed {
        logic [1:0] stage1; // First flip-flops, read only by stage2
        logic [1:0] stage2; // Second flip-flops, safe to use
    } rcf_sync_t;

endpackage

// [logic/rcf_reset_cause.sv]
// Reset-cause flag register, watchdog enable and reset clock-source choice
`timescale 1ns/1ps
`default_nettype none

module rcf_reset_cause (
    input wire logic clock, // System clock, 250 MHz
    input wire logic reset, // Power-on reset, synchronous, active high
    input wire logic clock_en, // Freezes all state while low
    input wire rcf_pkg::rcf_bus_req_t bus_req, // Register port request
    output logic [rcf_pkg::DATA_W-1:0] read_data, // Read data, cycle after read
    input wire rcf_pkg::rcf_events_t events, // Same-clock event pulses
    input wire rcf_pkg::rcf_config_t config_in, // Fuses and oscillator fields
    input wire logic master_clear_pin_n, // Reset pin, active low, asynchronous
    input wire logic brown_out_detect, // Brown-out detector, asynchronous
    output logic watchdog_run, // Watchdog enabled
    output logic [rcf_pkg::OSC_W-1:0] clock_source, // Clock source at last reset
    output logic [rcf_pkg::DATA_W-1:0] reset_cause, // Current flag word
    output logic irq // Level interrupt
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rcf_pkg::rcf_state_t r_reg; // Registered state
    rcf_pkg::rcf_state_t r_next; // Next state
    logic [1:0] pins_sync; // Synchronised pin levels
    logic pin_low; // Reset pin asserted, synchronised
    logic bor_high; // Brown-out asserted, synchronised
    logic pin_event; // Pin reset pulse
    logic bor_event; // Brown-out reset pulse
    logic [rcf_pkg::DATA_W-1:0] set_vec; // Hardware set requests, flag layout
    logic [rcf_pkg::DATA_W-1:0] cause_base; // Flag word before hardware sets
    logic hit_cause; // Address selects reset_cause_control
    logic hit_status; // Address selects the status register
    logic hit_mask; // Address selects the mask register
    logic hit_clk; // Address selects the clock status
    logic any_reset; // Some device reset happened this cycle

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Both pins come from outside the clock domain
    rcf_sync u_sync (
        .clock(clock),
        .reset(reset),
        .clock_en(clock_en),
        .async_in({brown_out_detect, master_clear_pin_n}),
        .sync_out(pins_sync)
    );

    assign pin_low = ~pins_sync[rcf_pkg::LANE_PIN];
    assign bor_high = pins_sync[rcf_pkg::LANE_BOR];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Unmapped addresses read zero and ignore writes
    always_comb begin
        hit_cause = (bus_req.addr == rcf_pkg::OFF_RESET_CAUSE);
        hit_status = (bus_req.addr == rcf_pkg::OFF_INT_STATUS);
        hit_mask = (bus_req.addr == rcf_pkg::OFF_INT_MASK);
        hit_clk = (bus_req.addr == rcf_pkg::OFF_CLK_STATUS);
    end

    // ------------------------------------------------------------
    // Event pulses
    // ------------------------------------------------------------
    // One pulse on the assert edge of each pin, so a held pin counts once
    always_comb begin
        pin_event = pin_low & ~r_reg.pin_prev;
        bor_event = bor_high & ~r_reg.bor_prev;
    end

    // Gather every hardware set request into the flag layout
    always_comb begin
        set_vec = rcf_pkg::ZERO_WORD;
        set_vec[rcf_pkg::BIT_TRAP_CONFLICT] = events.trap_conflict;
        set_vec[rcf_pkg::BIT_ILLEGAL_OP] = events.illegal_op;
        set_vec[rcf_pkg::BIT_CFG_MISMATCH] = events.config_mismatch;
        set_vec[rcf_pkg::BIT_PIN_RESET] = pin_event;
        set_vec[rcf_pkg::BIT_SOFT_RESET] = events.soft_reset;
        set_vec[rcf_pkg::BIT_WDT_TIMEOUT] = events.wdt_expire;
        set_vec[rcf_pkg::BIT_SLEEP] = events.save_sleep;
        set_vec[rcf_pkg::BIT_IDLE] = events.save_idle;
        // Deep sleep needs the enable of deep_sleep_control as well
        set_vec[rcf_pkg::BIT_DEEP_SLEEP] =
            events.save_sleep & config_in.deep_sleep_enable;
        set_vec[rcf_pkg::BIT_BROWN_OUT] = bor_event;
        any_reset = |(set_vec & rcf_pkg::RESET_EVENT_MASK);
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        cause_base = r_reg.reset_cause;
        if (clock_en) begin
            // Pin history for edge detection
            r_next.pin_prev = pin_low;
            r_next.bor_prev = bor_high;

            // Software write replaces the flag word without resetting anything
            if (bus_req.write && hit_cause) begin
                cause_base = bus_req.wdata & rcf_pkg::RESET_CAUSE_MASK;
            end
            // Any power-save instruction clears the time-out flag
            if (events.save_sleep || events.save_idle) begin
                cause_base[rcf_pkg::BIT_WDT_TIMEOUT] = 1'b0;
            end
            // Sets win over software and instruction clears in the same cycle;
            // untouched bits keep their value
            r_next.reset_cause = (cause_base | set_vec) & rcf_pkg::RESET_CAUSE_MASK;

            // Mask register
            if (bus_req.write && hit_mask) begin
                r_next.int_mask = bus_req.wdata & rcf_pkg::RESET_CAUSE_MASK;
            end

            // Status: a read clears, a new event in that cycle survives
            if (bus_req.read && hit_status) begin
                r_next.int_status = set_vec;
            end else begin
                r_next.int_status = r_reg.int_status | set_vec;
            end

            // Clock source: power-on choice made once reset is released
            if (r_reg.por_pending) begin
                r_next.clk_src = config_in.new_osc_fuse;
                r_next.por_pending = 1'b0;
            end else if (any_reset) begin
                if (!config_in.clock_switch_enable) begin
                    r_next.clk_src = config_in.new_osc_fuse;
                end else if (bor_event) begin
                    r_next.clk_src = config_in.new_osc_fuse;
                end else begin
                    r_next.clk_src = config_in.current_osc_field;
                end
            end

            // Read data stand for one cycle only
            r_next.rdata = rcf_pkg::ZERO_WORD;
            if (bus_req.read) begin
                case (1'b1)
                    hit_cause: begin
                        r_next.rdata = r_reg.reset_cause;
                    end
                    hit_status: begin
                        r_next.rdata = r_reg.int_status;
                    end
                    hit_mask: begin
                        r_next.rdata = r_reg.int_mask;
                    end
                    hit_clk: begin
                        r_next.rdata = {{(rcf_pkg::DATA_W-rcf_pkg::OSC_W){1'b0}},
                                        r_reg.clk_src};
                    end
                    default: begin
                        r_next.rdata = rcf_pkg::ZERO_WORD;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on reset loads the power-on and brown-out flags; the fuse clock
    // choice is taken one cycle later since reset loads constants only
    always_ff @(posedge clock) begin
        if (reset) begin
            r_reg.reset_cause <= rcf_pkg::RESET_CAUSE_POR;
            r_reg.int_status <= rcf_pkg::RESET_CAUSE_POR;
            r_reg.int_mask <= rcf_pkg::ZERO_WORD;
            r_reg.clk_src <= '0;
            r_reg.por_pending <= 1'b1;
            r_reg.rdata <= rcf_pkg::ZERO_WORD;
            r_reg.pin_prev <= 1'b0;
            r_reg.bor_prev <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Unprogrammed fuse overrides the software enable
    always_comb begin
        watchdog_run = config_in.watchdog_fuse_enable
            | r_reg.reset_cause[rcf_pkg::BIT_SOFT_WDT_EN];
        irq = |(r_reg.int_status & r_reg.int_mask);
    end

    assign read_data = r_reg.rdata;
    assign clock_source = r_reg.clk_src;
    assign reset_cause = r_reg.reset_cause;

endmodule // rcf_reset_cause

`default_nettype wire

// [logic/rcf_sync.sv]
// Two-flip-flop synchroniser for the asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module rcf_sync (
    input wire logic clock, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic clock_en, // Freezes state while low
    input wire logic [1:0] async_in, // Levels from outside the clock domain
    output logic [1:0] sync_out // Synchronised levels
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rcf_pkg::rcf_sync_t s_reg; // Registered state
    rcf_pkg::rcf_sync_t s_next; // Next state

    // Stage one feeds stage two only, keeping metastability off the logic
    always_comb begin
        s_next = s_reg;
        if (clock_en) begin
            s_next.stage1 = async_in;
            s_next.stage2 = s_reg.stage1;
        end
    end

    // Register the state
    always_ff @(posedge clock) begin
        if (reset) begin
            s_reg <= {rcf_pkg::SYNC_RESET_VALUE, rcf_pkg::SYNC_RESET_VALUE};
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stage2;

endmodule // rcf_sync

`default_nettype wire

// [verif/rcf_reset_cause_chk.sv]
// Assertion checker for the reset-cause flag block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module rcf_reset_cause_chk (
    input wire logic clock, // System clock
    input wire logic reset, // Power-on reset
    input wire logic clock_en, // State advance enable
    input wire rcf_pkg::rcf_bus_req_t bus_req, // Register port request
    input wire logic [rcf_pkg::DATA_W-1:0] read_data, // Read data
    input wire rcf_pkg::rcf_events_t events, // Event pulses
    input wire rcf_pkg::rcf_config_t config_in, // Fuses and fields
    input wire logic master_clear_pin_n, // Reset pin
    input wire logic brown_out_detect, // Brown-out detector
    input wire logic watchdog_run, // Watchdog enabled
    input wire logic [rcf_pkg::OSC_W-1:0] clock_source, // Chosen clock source
    input wire logic [rcf_pkg::DATA_W-1:0] reset_cause, // Flag word
    input wire logic irq // Level interrupt
);
    // ----------------------------------------
    // Clocking and named steps
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_read; clock_en && bus_req.read; endsequence // Accepted read strobe
    sequence s_quiet; clock_en && !bus_req.read; endsequence // Cycle without a read
    sequence s_save; clock_en && (events.save_sleep || events.save_idle); endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_WDT_RUN: assert property (
        watchdog_run == (reset_cause[5] | config_in.watchdog_fuse_enable))
        else $error("watchdog run level wrong");
    AST_WDT_SET: assert property (clock_en && events.wdt_expire |=> reset_cause[4])
        else $error("timeout flag not set");
    AST_WDT_CLR: assert property (
        s_save ##0 !events.wdt_expire && !bus_req.write |=> !reset_cause[4])
        else $error("timeout flag not cleared by power save");
    AST_SLEEP: assert property (clock_en && events.save_sleep |=> reset_cause[3])
        else $error("sleep flag not set");
    AST_IDLE: assert property (clock_en && events.save_idle |=> reset_cause[2])
        else $error("idle flag not set");
    AST_DEEP: assert property (
        clock_en && events.save_sleep && config_in.deep_sleep_enable |=> reset_cause[10])
        else $error("deep sleep flag not set");
    AST_TRAP: assert property (clock_en && events.trap_conflict |=> reset_cause[15])
        else $error("trap flag not set");
    // The clock choice of a soft reset depends on the switch level seen with the pulse
    AST_SOFT: assert property (
        clock_en && events.soft_reset |=> reset_cause[6]
        && clock_source == ($past(config_in.clock_switch_enable)
        ? $past(config_in.current_osc_field) : $past(config_in.new_osc_fuse)))
        else $error("soft reset flag or clock source wrong");
    AST_POR: assert property (
        disable iff (1'b0) reset
        |=> reset_cause == 16'h0003 && read_data == 16'h0000 && !irq)
        else $error("power-on values wrong");
    AST_POR_CLK: assert property (
        $fell(reset) && clock_en |-> ##[1:2] clock_source == config_in.new_osc_fuse)
        else $error("power-on clock source wrong");
    AST_CAUSE_READ: assert property (
        s_read ##0 bus_req.addr == rcf_pkg::OFF_RESET_CAUSE
        |=> read_data == $past(reset_cause))
        else $error("flag word read wrong");
    AST_READ_DROP: assert property (s_read ##1 s_quiet |=> read_data == 16'h0000)
        else $error("read data held too long");
endmodule // rcf_reset_cause_chk

bind rcf_reset_cause rcf_reset_cause_chk u_rcf_reset_cause_chk (.clock(clock), .reset(reset),
    .clock_en(clock_en), .bus_req(bus_req), .read_data(read_data), .events(events),
    .config_in(config_in), .master_clear_pin_n(master_clear_pin_n),
    .brown_out_detect(brown_out_detect), .watchdog_run(watchdog_run),
    .clock_source(clock_source), .reset_cause(reset_cause), .irq(irq));

`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the reset-cause flag block
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock = 1'b0; // 250 MHz clock
    logic reset = 1'b1; // Power-on reset
    logic clock_en = 1'b1; // Keep state moving
    rcf_pkg::rcf_bus_req_t bus_req = '0; // Register port
    rcf_pkg::rcf_events_t events = '0; // Event pulses
    rcf_pkg::rcf_config_t config_in = 9'h0D4; // Switching on, fuse field 5, current field 2
    logic master_clear_pin_n = 1'b1; // Pin released
    logic brown_out_detect = 1'b0; // Supply good
    logic [15:0] read_data, reset_cause, rd, wv; // Outputs and scratch
    logic [2:0] clock_source, src_exp; // Seen and expected clock source
    logic watchdog_run, irq; // Level outputs
    logic [31:0] seed = 32'h00017D8A; // Fixed xorshift seed
    int mismatches = 0, comparisons = 0, cycles = 0;

    rcf_reset_cause u_rcf_reset_cause (.clock(clock), .reset(reset), .clock_en(clock_en),
        .bus_req(bus_req), .read_data(read_data), .events(events), .config_in(config_in),
        .master_clear_pin_n(master_clear_pin_n), .brown_out_detect(brown_out_detect),
        .watchdog_run(watchdog_run), .clock_source(clock_source), .reset_cause(reset_cause),
        .irq(irq));

    initial begin
        forever #2 clock = ~clock;
    end

    // Hang guard, far above the planned run of about 170 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Flags one event leaves set; index counts from the event struct lsb
    function automatic logic [15:0] ev_bits(int i, logic deep);
        case (i)
            0: return 16'h0004;
            1: return deep ? 16'h0408 : 16'h0008;
            2: return 16'h0010;
            3: return 16'h0040;
            4: return 16'h0200;
            5: return 16'h4000;
            default: return 16'h8000;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus_req.write <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read(input logic [3:0] a);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
        @(posedge clock);
        bus_req.read <= 1'b0;
        #1 rd = read_data;
    endtask

    task automatic pulse(input logic [6:0] e);
        @(posedge clock);
        events <= rcf_pkg::rcf_events_t'(e);
        @(posedge clock);
        events <= '0;
        #1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        src_exp = 3'h5;
        repeat (3) @(posedge clock);
        #1 check(reset_cause, 16'h0003);
        check({13'h0000, clock_source}, {13'h0000, src_exp});
        bus_read(rcf_pkg::OFF_INT_STATUS);
        check(rd, 16'h0003);
        bus_read(rcf_pkg::OFF_INT_STATUS);
        check(rd, 16'h0000);
        bus_read(4'h2);
        check(rd, 16'h0000);
        bus_write(rcf_pkg::OFF_CLK_STATUS, 16'hFFFF);
        bus_read(rcf_pkg::OFF_CLK_STATUS);
        check(rd, {13'h0000, src_exp});
        // Software writes: any pattern, no reset, watchdog follows bit five or fuse
        for (int k = 0; k < 8; k++) begin
            wv = (k == 0) ? 16'hFFFF : 16'(rnd());
            @(posedge clock);
            config_in.watchdog_fuse_enable <= wv[8];
            bus_write(rcf_pkg::OFF_RESET_CAUSE, wv);
            check({15'h0000, watchdog_run}, {15'h0000, wv[5] | wv[8]});
            bus_read(rcf_pkg::OFF_RESET_CAUSE);
            check(rd, wv & 16'hC6FF);
            check({13'h0000, clock_source}, {13'h0000, src_exp});
        end
        // Every event with switching off then on, random fields
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 7; i++) begin
                wv = 16'(rnd());
                @(posedge clock);
                config_in <= rcf_pkg::rcf_config_t'({1'b0, s[0], wv[2:0], wv[5:3], wv[6]});
                bus_write(rcf_pkg::OFF_RESET_CAUSE, 16'h0000);
                if (i > 1) begin
                    src_exp = s[0] ? wv[5:3] : wv[2:0];
                end
                pulse(7'h01 << i);
                check(reset_cause, ev_bits(i, wv[6]));
                check({13'h0000, clock_source}, {13'h0000, src_exp});
            end
        end
        // Power save clears timeout; timeout in the same cycle wins; deep sleep enabled
        @(posedge clock);
        config_in.deep_sleep_enable <= 1'b1;
        pulse(7'h04);
        pulse(7'h01);
        check(reset_cause, 16'h8004);
        pulse(7'h06);
        check(reset_cause, 16'h841C);
        // Pin reset takes the current field, brown-out the fuse field
        bus_write(rcf_pkg::OFF_RESET_CAUSE, 16'h0000);
        @(posedge clock);
        master_clear_pin_n <= 1'b0;
        repeat (5) @(posedge clock);
        master_clear_pin_n <= 1'b1;
        #1 check(reset_cause, 16'h0080);
        check({13'h0000, clock_source}, {13'h0000, config_in.current_osc_field});
        @(posedge clock);
        brown_out_detect <= 1'b1;
        repeat (5) @(posedge clock);
        brown_out_detect <= 1'b0;
        #1 check(reset_cause, 16'h0082);
        check({13'h0000, clock_source}, {13'h0000, config_in.new_osc_fuse});
        // Interrupt raised, masked, unmasked and cleared by reading status
        bus_read(rcf_pkg::OFF_INT_STATUS);
        bus_write(rcf_pkg::OFF_INT_MASK, 16'h0010);
        check({15'h0000, irq}, 16'h0000);
        pulse(7'h04);
        check({15'h0000, irq}, 16'h0001);
        bus_write(rcf_pkg::OFF_INT_MASK, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        bus_write(rcf_pkg::OFF_INT_MASK, 16'h0010);
        bus_read(rcf_pkg::OFF_INT_STATUS);
        check(rd, 16'h0010);
        check({15'h0000, irq}, 16'h0000);
        // Clock enable low: an event and a write are both ignored
        @(posedge clock);
        clock_en <= 1'b0;
        pulse(7'h40);
        bus_write(rcf_pkg::OFF_RESET_CAUSE, 16'hFFFF);
        check(reset_cause, 16'h0092);
        // Mid-run power-on reset clears event flags and takes the fuse clock again
        @(posedge clock);
        clock_en <= 1'b1;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check(reset_cause, 16'h0003);
        check({13'h0000, clock_source}, {13'h0000, config_in.new_osc_fuse});
        bus_read(rcf_pkg::OFF_INT_STATUS);
        check(rd, 16'h0003);
        end_sim();
    end
endmodule // tb

`default_nettype wire
